// [core/aiex_exec.sv]
// Executes add and AND instructions against an accumulator and a file register bank.
// Assumes an Avalon-MM master with waitrequest on the same clock; no other clocks.
// Function
// - Register add: acc plus file, flags C DC Z
// - Destination bit zero to acc, one to file
// - Register AND: acc and file, zero flag only
// - Literal AND into acc, zero flag only
`timescale 1ns/1ps
module aiex_exec #(
  parameter int FILE_DEPTH = 128  // File register count, indexed by seven bits
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Core state seen by the rest of the datapath
  output logic [7:0]       ACC,
  output logic [3:0]       STATUS
);
  import aiex_pkg::*;

  logic [7:0]  acc_q, acc_d;                        // Accumulator
  logic [3:0]  status_q, status_d;                  // Flags and sticky unknown-opcode bit
  logic [6:0]  index_q, index_d;                    // File pointer
  logic [7:0]  file_q [FILE_DEPTH];                 // File register bank
  logic [7:0]  file_d [FILE_DEPTH];
  logic        wait_q, wait_d;                      // Registered waitrequest
  logic [31:0] rdata_q, rdata_d;                    // Registered read data
  logic        accept;                              // Edge at which the master is released
  logic        exec;                                // Instruction write taken this edge
  logic [7:0]  alu_result;
  logic        alu_c, alu_dc, alu_z, alu_to_acc, alu_to_file, alu_arith, alu_known;

  // The request is taken at the edge where waitrequest is already low
  assign accept = (AVS_READ || AVS_WRITE) && !wait_q;
  // An instruction needs both low byte lanes; a partial write would be half an opcode
  assign exec   = accept && AVS_WRITE && (AVS_ADDRESS == OFS_INSTR)
                  && (AVS_BYTEENABLE[1:0] == 2'b11);

  // Decoder works on the word being written and the file slot its field names
  aiex_alu u_alu (
    .instr      (AVS_WRITEDATA[13:0]),
    .acc        (acc_q),
    .file_val   (file_q[AVS_WRITEDATA[6:0]]),
    .result     (alu_result),
    .carry      (alu_c),
    .half_carry (alu_dc),
    .zero       (alu_z),
    .to_acc     (alu_to_acc),
    .to_file    (alu_to_file),
    .arith      (alu_arith),
    .known      (alu_known)
  );

  // Bus handshake: one wait cycle, then the answer for one cycle
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    // A request seen while idle is answered at the next edge; read data stand until the next one
    if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_d  = 1'b0;                                // Answer next cycle
      rdata_d = 32'h0000_0000;                       // Unmapped reads give zero
      case (AVS_ADDRESS)
        OFS_ACC:        rdata_d[7:0] = acc_q;
        OFS_STATUS:     rdata_d[3:0] = status_q;
        OFS_FILE_INDEX: rdata_d[6:0] = index_q;
        OFS_FILE_DATA:  rdata_d[7:0] = file_q[index_q];
        default:        rdata_d      = 32'h0000_0000;
      endcase
    end
  end

  // Architectural state next values
  always_comb begin
    acc_d    = acc_q;
    status_d = status_q;
    index_d  = index_q;
    file_d   = file_q;
    if (accept && AVS_WRITE && AVS_BYTEENABLE[0]) begin
      case (AVS_ADDRESS)
        OFS_ACC:        acc_d    = AVS_WRITEDATA[7:0];
        OFS_STATUS:     status_d = AVS_WRITEDATA[3:0];
        OFS_FILE_INDEX: index_d  = AVS_WRITEDATA[6:0];
        OFS_FILE_DATA:  file_d[index_q] = AVS_WRITEDATA[7:0];
        default:        acc_d    = acc_q;            // Unmapped writes are dropped
      endcase
    end
    // Instruction effects; operands are the values held before this edge
    if (exec) begin
      if (alu_known) begin
        if (alu_to_acc) begin
          acc_d = alu_result;
        end
        if (alu_to_file) begin
          file_d[AVS_WRITEDATA[6:0]] = alu_result;
        end
        status_d[BIT_ZERO] = alu_z;
        if (alu_arith) begin
          status_d[BIT_CARRY]      = alu_c;
          status_d[BIT_HALF_CARRY] = alu_dc;
        end
      end else begin
        // Set wins even against a status write in the same cycle
        status_d[BIT_UNSUPP] = 1'b1;
      end
    end
  end

  // Bus registers; waitrequest idles high so a master never sees a stale grant out of reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Architectural registers; the file bank is cleared too so reads are never unknown
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      acc_q    <= RST_ACC;
      status_q <= RST_STATUS;
      index_q  <= RST_FILE_INDEX;
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_q[i] <= RST_FILE;
      end
    end else begin
      acc_q    <= acc_d;
      status_q <= status_d;
      index_q  <= index_d;
      file_q   <= file_d;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA    = rdata_q;
  assign ACC             = acc_q;
  assign STATUS          = status_q;

  // Checking helpers: expected values computed from pre-edge state
  logic [8:0] exp_sum;
  logic [4:0] exp_half;
  logic [7:0] exp_and;
  logic [7:0] exp_file;
  logic [6:0] exp_fidx;
  logic [7:0] exp_opnd;
  logic       is_add_f, is_and_f, is_and_i, is_add_i, dest_bit;
  // Opcode strobes, qualified by the accepted instruction write
  assign is_add_f = exec && (AVS_WRITEDATA[13:8] == OP_ADD_FILE);
  assign is_and_f = exec && (AVS_WRITEDATA[13:8] == OP_AND_FILE);
  assign is_and_i = exec && (AVS_WRITEDATA[13:8] == OP_AND_IMM);
  assign is_add_i = exec && (AVS_WRITEDATA[13:9] == OP_ADD_IMM);
  assign dest_bit = AVS_WRITEDATA[BIT_DEST];
  // Reference arithmetic, worked out apart from the decoder's own datapath
  assign exp_fidx = AVS_WRITEDATA[6:0];
  assign exp_file = file_q[exp_fidx];
  assign exp_opnd = (is_and_i || is_add_i) ? AVS_WRITEDATA[7:0] : exp_file;
  assign exp_sum  = {1'b0, acc_q} + {1'b0, exp_opnd};
  assign exp_half = {1'b0, acc_q[3:0]} + {1'b0, exp_opnd[3:0]};
  assign exp_and  = acc_q & exp_opnd;

  // Instruction checks look one edge after an accepted instruction word; a_bus_answer follows any bus request
  a_add_file_acc: assert property (@(posedge CORE_CLK) disable iff (RST)
    is_add_f && !dest_bit |=> acc_q == $past(exp_sum[7:0])
      && status_q[BIT_CARRY] == $past(exp_sum[8])
      && status_q[BIT_HALF_CARRY] == $past(exp_half[4])
      && status_q[BIT_ZERO] == ($past(exp_sum[7:0]) == 8'h00))
    else $error("Register add result or flags wrong");

  a_dest_file_kept: assert property (@(posedge CORE_CLK) disable iff (RST)
    (is_add_f || is_and_f) && dest_bit |=> acc_q == $past(acc_q))
    else $error("Accumulator changed when destination is file");

  a_dest_file_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    is_add_f && dest_bit |=> file_q[$past(exp_fidx)] == $past(exp_sum[7:0]))
    else $error("Register add did not write the file");

  a_and_file_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    is_and_f && dest_bit |=> file_q[$past(exp_fidx)] == $past(exp_and))
    else $error("Register AND did not write the file");

  a_and_file_flags: assert property (@(posedge CORE_CLK) disable iff (RST)
    is_and_f && !dest_bit |=> acc_q == $past(exp_and)
      && status_q[1:0] == $past(status_q[1:0])
      && status_q[BIT_ZERO] == (acc_q == 8'h00))
    else $error("Register AND result or flags wrong");

  a_and_imm_acc: assert property (@(posedge CORE_CLK) disable iff (RST)
    is_and_i |=> acc_q == $past(exp_and) && status_q[BIT_CARRY] == $past(status_q[BIT_CARRY]))
    else $error("Literal AND result or carry wrong");

  a_add_imm_acc: assert property (@(posedge CORE_CLK) disable iff (RST)
    is_add_i |=> acc_q == $past(exp_sum[7:0]) && status_q[BIT_CARRY] == $past(exp_sum[8])
      && status_q[BIT_HALF_CARRY] == $past(exp_half[4])
      && status_q[BIT_ZERO] == ($past(exp_sum[7:0]) == 8'h00))
    else $error("Literal add result or flags wrong");

  a_bus_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("Bus answer not one cycle after request");

  a_unsupp_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec && !(is_add_f || is_and_f || is_and_i || is_add_i) |=> status_q[BIT_UNSUPP])
    else $error("Unknown opcode not flagged");

  c_add_file_dest: cover property (@(posedge CORE_CLK) disable iff (RST) is_add_f && dest_bit);
  c_add_imm_carry: cover property (@(posedge CORE_CLK) disable iff (RST) is_add_i && exp_sum[8]);
  c_and_zero:      cover property (@(posedge CORE_CLK) disable iff (RST)
    is_and_f && exp_and == 8'h00);
  // Main scenarios; instruction writes can land every second edge at the fastest master pace, every third in this bench
  c_back_to_back:  cover property (@(posedge CORE_CLK) disable iff (RST) exec ##3 exec);
  c_unknown_op:    cover property (@(posedge CORE_CLK) disable iff (RST) exec && !alu_known);

endmodule : aiex_exec

// [core/aiex_pkg.sv]
// Shared constants for the add/and instruction execution block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package aiex_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFS_INSTR      = 8'h00;  // Write executes an instruction word
  localparam logic [7:0]  OFS_ACC        = 8'h04;  // Accumulator
  localparam logic [7:0]  OFS_STATUS     = 8'h08;  // Flags
  localparam logic [7:0]  OFS_FILE_INDEX = 8'h0C;  // File register pointer
  localparam logic [7:0]  OFS_FILE_DATA  = 8'h10;  // File register at the pointer

  // Status bit positions
  localparam int          BIT_CARRY      = 0;
  localparam int          BIT_HALF_CARRY = 1;
  localparam int          BIT_ZERO       = 2;
  localparam int          BIT_UNSUPP     = 3;      // Sticky: unknown opcode seen

  // Reset values
  localparam logic [7:0]  RST_ACC        = 8'h00;
  localparam logic [3:0]  RST_STATUS     = 4'h0;
  localparam logic [6:0]  RST_FILE_INDEX = 7'h00;
  localparam logic [7:0]  RST_FILE       = 8'h00;

  // Instruction word layout
  localparam int          INSTR_W        = 14;
  localparam int          BIT_DEST       = 7;      // Destination select
  localparam logic [5:0]  OP_ADD_FILE    = 6'h07;  // Bits 13:8
  localparam logic [5:0]  OP_AND_FILE    = 6'h05;  // Bits 13:8
  localparam logic [5:0]  OP_AND_IMM     = 6'h39;  // Bits 13:8
  localparam logic [4:0]  OP_ADD_IMM     = 5'h1F;  // Bits 13:9, bit 8 ignored

  // Bus answer latency in cycles after a request appears
  localparam int          BUS_LATENCY    = 1;

endpackage : aiex_pkg

// [core/aiex_alu.sv]
// Decoder and arithmetic unit for the four supported instructions.
// Purely combinational; the caller supplies the accumulator and the addressed file value.
`timescale 1ns/1ps
module aiex_alu (
  // Operands
  input  wire logic [13:0] instr,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  file_val,
  // Results
  output logic [7:0]       result,
  output logic             carry,
  output logic             half_carry,
  output logic             zero,
  output logic             to_acc,
  output logic             to_file,
  output logic             arith,
  output logic             known
);
  import aiex_pkg::*;

  logic [8:0] sum_full;   // Nine bits keep the carry out
  logic [4:0] sum_low;    // Low nibble sum gives the half carry
  logic [7:0] operand;    // Literal or file value

  // Decode and compute
  always_comb begin
    sum_full   = 9'h000;
    sum_low    = 5'h00;
    operand    = file_val;
    result     = 8'h00;
    to_acc     = 1'b0;
    to_file    = 1'b0;
    arith      = 1'b0;
    known      = 1'b1;
    if (instr[13:9] == OP_ADD_IMM) begin
      operand = instr[7:0];
      arith   = 1'b1;
      to_acc  = 1'b1;
    end else if (instr[13:8] == OP_AND_IMM) begin
      operand = instr[7:0];
      to_acc  = 1'b1;
    end else if (instr[13:8] == OP_ADD_FILE) begin
      arith   = 1'b1;
      to_acc  = ~instr[BIT_DEST];
      to_file = instr[BIT_DEST];
    end else if (instr[13:8] == OP_AND_FILE) begin
      to_acc  = ~instr[BIT_DEST];
      to_file = instr[BIT_DEST];
    end else begin
      // Anything else is outside this block and only raises the sticky unknown-opcode flag
      known = 1'b0;
    end
    sum_full = {1'b0, acc} + {1'b0, operand};
    sum_low  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
    result   = arith ? sum_full[7:0] : (acc & operand);
  end

  // Flags: the caller only stores carry and half carry when arith is set
  assign carry      = sum_full[8];
  assign half_carry = sum_low[4];
  assign zero       = (result == 8'h00);

endmodule : aiex_alu

// [tb/testbench.sv]
// Self-checking bench for the add/and instruction execution block.
// Assumes the block answers each bus request with waitrequest and holds no other clock.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module testbench;
  import aiex_pkg::*;
  // Bench side of the ports
  logic        clk;                  // Core clock
  logic        rst;                  // Synchronous reset
  logic [7:0]  adr;                  // Bus address
  logic        rd;                   // Read strobe
  logic        wr;                   // Write strobe
  logic [3:0]  be;                   // Byte lanes
  logic [31:0] wdat;                 // Write data
  logic [31:0] rdat;                 // Read data
  logic        wait_req;             // Slave stall
  logic [7:0]  acc;                  // Accumulator at the port
  logic [3:0]  status;               // Flags at the port
  // Bookkeeping
  int          n_errors = 0;         // Mismatches seen
  int          checks   = 0;         // Comparisons made
  logic [31:0] seed     = 32'h0000_9233; // Fixed start so every run repeats
  // Reference state worked out by the bench
  logic [7:0]  m_acc;                // Expected accumulator
  logic [3:0]  m_st;                 // Expected flags
  logic [7:0]  m_file [128];         // Expected file bank

  aiex_exec #(.FILE_DEPTH(128)) DUT (
    .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_req), .ACC(acc), .STATUS(status));

  // Free-running core clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Xorshift source for repeatable stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // One bus transfer; held until waitrequest is sampled low, then one idle edge
  // so the strobe is never lowered and raised in the same time step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    // Any number of wait cycles is accepted; only the watchdog ends a stall
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Expected effect of one instruction word on the reference state
  function automatic void model(input logic [13:0] ins);
    logic       lit;
    logic       add;
    logic [7:0] src;
    logic [8:0] sum;
    logic [7:0] res;
    lit = ins[13:12] == 2'b11;
    add = ins[13:8] == OP_ADD_FILE || ins[13:9] == OP_ADD_IMM;
    src = lit ? ins[7:0] : m_file[ins[6:0]];
    // Anything outside the four opcodes only raises the sticky flag
    if (!(add || ins[13:8] == OP_AND_FILE || ins[13:8] == OP_AND_IMM)) begin
      m_st[BIT_UNSUPP] = 1'b1;
      return;
    end
    sum = {1'b0, m_acc} + {1'b0, src};
    res = add ? sum[7:0] : (m_acc & src);
    if (add) begin
      m_st[BIT_CARRY]      = sum[8];
      m_st[BIT_HALF_CARRY] = ({1'b0, m_acc[3:0]} + {1'b0, src[3:0]}) > 5'h0F;
    end
    m_st[BIT_ZERO] = res == 8'h00;
    if (!lit && ins[BIT_DEST]) m_file[ins[6:0]] = res;
    else m_acc = res;
  endfunction : model

  // Load operands over the bus, execute, then compare accumulator, flags and the addressed file register
  task automatic run(input logic [7:0] a, input logic [7:0] fv, input logic [13:0] ins);
    logic [31:0] q;
    bus(1'b1, OFS_ACC, {24'h0, a}, q);
    bus(1'b1, OFS_FILE_INDEX, {25'h0, ins[6:0]}, q);
    bus(1'b1, OFS_FILE_DATA, {24'h0, fv}, q);
    m_acc = a;
    m_file[ins[6:0]] = fv;
    bus(1'b1, OFS_INSTR, {18'h0, ins}, q);
    model(ins);
    `CHK(acc, m_acc)
    `CHK(status, m_st)
    bus(1'b0, OFS_FILE_DATA, 32'h0, q);
    `CHK(q, {24'h0, m_file[ins[6:0]]})
  endtask : run

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Cut a hang short: the full run needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic [13:0] ins;
    rst <= 1'b1;
    adr <= 8'h00;
    rd <= 1'b0;
    wr <= 1'b0;
    be <= 4'hF;
    wdat <= 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(acc, RST_ACC)
    `CHK(status, RST_STATUS)
    m_acc = RST_ACC;
    m_st  = RST_STATUS;
    bus(1'b0, 8'h20, 32'h0, q);
    `CHK(q, 32'h0)
    $display("test reset_and_map done");
    // Hand-picked corners: worked examples, carry and half-carry edges, zero results
    run(8'h17, 8'hC2, {OP_ADD_FILE, 1'b0, 7'h05});
    run(8'h17, 8'hC2, {OP_AND_FILE, 1'b1, 7'h05});
    run(8'hA3, 8'h00, {OP_AND_IMM, 8'h5F});
    run(8'hFF, 8'h00, {OP_ADD_IMM, 1'b0, 8'h01});
    run(8'h08, 8'h00, {OP_ADD_IMM, 1'b1, 8'h08});
    run(8'h80, 8'h80, {OP_ADD_FILE, 1'b1, 7'h7F});
    run(8'h0F, 8'hF0, {OP_AND_FILE, 1'b0, 7'h00});
    $display("test corners done");
    // Random mix of all four opcodes, both destinations
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      q = rnd();
      case (r[1:0])
        2'd0:    ins = {OP_ADD_FILE, q[7:0]};
        2'd1:    ins = {OP_AND_FILE, q[7:0]};
        2'd2:    ins = {OP_AND_IMM, q[7:0]};
        default: ins = {OP_ADD_IMM, q[8:0]};
      endcase
      run(r[15:8], r[23:16], ins);
    end
    $display("test random_mix done");
    // Unknown opcode must leave data alone
    run(8'h11, 8'h22, 14'h0000);
    // An instruction word with lane 1 off is half an opcode and must be dropped
    be <= 4'h1;
    bus(1'b1, OFS_INSTR, {18'h0, OP_AND_IMM, 8'h00}, q);
    be <= 4'hF;
    `CHK(acc, m_acc)
    // Two instruction writes at the fastest pace of this bench
    bus(1'b1, OFS_INSTR, {18'h0, OP_ADD_IMM, 1'b0, 8'h0F}, q);
    model({OP_ADD_IMM, 1'b0, 8'h0F});
    bus(1'b1, OFS_INSTR, {18'h0, OP_AND_IMM, 8'hF0}, q);
    model({OP_AND_IMM, 8'hF0});
    `CHK(acc, m_acc)
    `CHK(status, m_st)
    // Architectural registers read back over the bus
    bus(1'b0, OFS_ACC, 32'h0, q);
    `CHK(q, {24'h0, m_acc})
    bus(1'b0, OFS_STATUS, 32'h0, q);
    `CHK(q, {28'h0, m_st})
    $display("test lanes_and_readback done");
    // Reset again in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(acc, RST_ACC)
    `CHK(status, RST_STATUS)
    $display("test unknown_and_rereset done");
    tally_and_finish();
  end
endmodule : testbench
